// ==== rtl/tecnt_pkg.sv ====
// Constants for the 16-bit timer/event counter: register map, field positions,
// reset values, encodings and timing.
// Assumes one 125 MHz clock and an AHB-Lite master issuing single word transfers.
//
// Function
// - Clock and edge select register resets to zero, readable and writable.
// - Second input edge field bits 7:6: 00 fall, 01 rise, 11 both.
// - First input edge field bits 5:4: 00 fall, 01 rise, 11 both.
// - Count source bits 1:0: clock, clock/4, watch tick, first input edges.
// - First enable with input high and rising selection counts as a rising edge.
// - Run mode 11 starts counting synchronously with the selected count clock.
// - In clear-on-match mode a match clears the counter and raises match A.
// - Output control value 03H in interval mode gives a square wave.
// - Square wave: each match clears, interrupts and inverts the output.
// - Output enable bit at 0 holds the timer output low.
// - Source 11 with run mode 11 counts edges and interrupts on match.
// - Event counting: first match after compare plus two edges, then plus one.
// - First input sampled at clock/4; edge accepted after two equal samples.
// - Run mode 00 stops the count clock and clears the counter.
// - Overflow flag sets when the counter wraps from FFFFH to zero.
// - Toggle bit enables output inversion on match; interrupt raised regardless.
package tecnt_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Register byte addresses
   localparam logic [7:0] ADDR_RUN_MODE_CONTROL = 8'h00;
   localparam logic [7:0] ADDR_CAPTURE_COMPARE  = 8'h04;
   localparam logic [7:0] ADDR_OUTPUT_CONTROL   = 8'h08;
   localparam logic [7:0] ADDR_CLOCK_EDGE_SEL   = 8'h0c;
   localparam logic [7:0] ADDR_COUNT_VALUE      = 8'h10;
   localparam logic [7:0] ADDR_COMPARE_A        = 8'h14;
   localparam logic [7:0] ADDR_COMPARE_B        = 8'h18;

   ////////////////////////////////////////////////////////////////////////////
   // Field positions
   localparam int RUN_MODE_LO_POS    = 2;
   localparam int OVERFLOW_POS       = 0;
   localparam int OUT_ENABLE_POS     = 0;
   localparam int TOGGLE_A_POS       = 1;
   localparam int LEVEL_CLEAR_POS    = 2;
   localparam int LEVEL_SET_POS      = 3;
   localparam int TOGGLE_B_POS       = 4;
   localparam int SECOND_EDGE_LO_POS = 6;
   localparam int FIRST_EDGE_LO_POS  = 4;
   localparam int COUNT_SRC_LO_POS   = 0;

   ////////////////////////////////////////////////////////////////////////////
   // Reset values
   localparam logic [7:0]  CLOCK_EDGE_SEL_RESET = 8'h00;
   localparam logic [7:0]  CONTROL_RESET        = 8'h00;
   localparam logic [15:0] COUNT_RESET          = 16'h0000;
   localparam logic [15:0] COMPARE_RESET        = 16'h0000;
   localparam logic [15:0] COUNT_MAX            = 16'hffff;

   ////////////////////////////////////////////////////////////////////////////
   // Encodings
   typedef enum logic [1:0] {
      TECNT_RUN_STOP      = 2'h0,
      TECNT_RUN_FREE      = 2'h1,
      TECNT_RUN_EDGE_CLR  = 2'h2,
      TECNT_RUN_MATCH_CLR = 2'h3
   } tecnt_run_t;

   typedef enum logic [1:0] {
      TECNT_SRC_CLK      = 2'h0,
      TECNT_SRC_CLK_DIV4 = 2'h1,
      TECNT_SRC_WATCH    = 2'h2,
      TECNT_SRC_EDGE_A   = 2'h3
   } tecnt_src_t;

   localparam logic [1:0] EDGE_FALL = 2'h0;
   localparam logic [1:0] EDGE_RISE = 2'h1;
   localparam logic [1:0] EDGE_BOTH = 2'h3;

   ////////////////////////////////////////////////////////////////////////////
   // Timing
   localparam int CLOCK_MHZ       = 125;
   localparam int PRESCALE_DIV    = 4;
   localparam logic [1:0] PRESCALE_LAST = 2'(PRESCALE_DIV - 1);

endpackage : tecnt_pkg

// ==== rtl/tecnt_timer.sv ====
// Timer/event counter with match-clear interval, square-wave output and
// filtered external event counting, registers on an AHB-Lite slave.
// Assumes pin inputs are asynchronous and the watch tick is a one-cycle
// pulse from logic on the same clock.
//
// Design decisions made here: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps

module tecnt_timer
   import tecnt_pkg::*;
(
   // Clock and reset
   input  wire logic        clock,
   input  wire logic        rst_n,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [7:0]  haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // Timing sources
   input  wire logic        watch_timer_tick,
   // Pins
   input  wire logic        event_input_a,
   input  wire logic        capture_input_b,
   output logic             timer_output_pin,
   // Match events
   output logic             match_irq_a,
   output logic             match_irq_b
);

   ////////////////////////////////////////////////////////////////////////////
   // Helpers

   function automatic logic edge_hit(input logic [1:0] sel, input logic old_lvl,
                                     input logic new_lvl);
      logic rise;
      logic fall;
      rise = ~old_lvl & new_lvl;
      fall = old_lvl & ~new_lvl;
      unique case (sel)
         EDGE_FALL: edge_hit = fall;
         EDGE_RISE: edge_hit = rise;
         EDGE_BOTH: edge_hit = rise | fall;
         default:   edge_hit = 1'b0;
      endcase
   endfunction : edge_hit

   ////////////////////////////////////////////////////////////////////////////
   // Registers

   logic [7:0]  clock_and_edge_select_reg;
   logic [1:0]  run_mode_reg;
   logic        overflow_flag_reg;
   logic [2:0]  capture_compare_control_reg;
   logic        output_enable_bit_reg;
   logic        toggle_on_match_a_reg;
   logic        toggle_on_match_b_reg;
   logic [15:0] count_value_reg;
   logic [15:0] compare_capture_a_reg;
   logic [15:0] compare_capture_b_reg;
   logic        out_level_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Bus slave: zero wait states, write committed in the data phase

   logic       wr_pend_reg;
   logic [7:0] wr_addr_reg;
   logic       addr_phase;
   logic [31:0] rd_next;

   assign addr_phase = hsel & hready & htrans[1];

   always_comb begin
      rd_next = 32'h0000_0000;
      unique case (haddr)
         ADDR_RUN_MODE_CONTROL: rd_next = {28'h0000000, run_mode_reg, 1'b0, overflow_flag_reg};
         ADDR_CAPTURE_COMPARE:  rd_next = {29'h00000000, capture_compare_control_reg};
         ADDR_OUTPUT_CONTROL:   rd_next = {27'h0000000, toggle_on_match_b_reg, 2'h0,
                                           toggle_on_match_a_reg, output_enable_bit_reg};
         ADDR_CLOCK_EDGE_SEL:   rd_next = {24'h000000, clock_and_edge_select_reg};
         ADDR_COUNT_VALUE:      rd_next = {16'h0000, count_value_reg};
         ADDR_COMPARE_A:        rd_next = {16'h0000, compare_capture_a_reg};
         ADDR_COMPARE_B:        rd_next = {16'h0000, compare_capture_b_reg};
         default:               rd_next = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 8'h00;
         hrdata      <= 32'h0000_0000;
         hreadyout   <= 1'b1;
         hresp       <= 1'b0;
      end else begin
         wr_pend_reg <= addr_phase & hwrite;
         if (addr_phase) begin
            wr_addr_reg <= haddr;
         end
         if (addr_phase & ~hwrite) begin
            hrdata <= rd_next;
         end
      end
   end

   logic wr_mode;
   logic wr_ctl;
   logic wr_out;
   logic wr_sel;
   logic wr_cmp_a;
   logic wr_cmp_b;

   assign wr_mode  = wr_pend_reg & (wr_addr_reg == ADDR_RUN_MODE_CONTROL);
   assign wr_ctl   = wr_pend_reg & (wr_addr_reg == ADDR_CAPTURE_COMPARE);
   assign wr_out   = wr_pend_reg & (wr_addr_reg == ADDR_OUTPUT_CONTROL);
   assign wr_sel   = wr_pend_reg & (wr_addr_reg == ADDR_CLOCK_EDGE_SEL);
   assign wr_cmp_a = wr_pend_reg & (wr_addr_reg == ADDR_COMPARE_A);
   assign wr_cmp_b = wr_pend_reg & (wr_addr_reg == ADDR_COMPARE_B);

   ////////////////////////////////////////////////////////////////////////////
   // Configuration registers

   // Changing the selection while running is left to software discipline
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         clock_and_edge_select_reg <= CLOCK_EDGE_SEL_RESET;
      end else if (wr_sel) begin
         clock_and_edge_select_reg <= hwdata[7:0];
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         run_mode_reg                <= CONTROL_RESET[1:0];
         capture_compare_control_reg <= CONTROL_RESET[2:0];
         compare_capture_a_reg       <= COMPARE_RESET;
         compare_capture_b_reg       <= COMPARE_RESET;
         output_enable_bit_reg       <= 1'b0;
         toggle_on_match_a_reg       <= 1'b0;
         toggle_on_match_b_reg       <= 1'b0;
      end else begin
         if (wr_mode) begin
            run_mode_reg <= hwdata[RUN_MODE_LO_POS +: 2];
         end
         if (wr_ctl) begin
            capture_compare_control_reg <= hwdata[2:0];
         end
         if (wr_cmp_a) begin
            compare_capture_a_reg <= hwdata[15:0];
         end
         if (wr_cmp_b) begin
            compare_capture_b_reg <= hwdata[15:0];
         end
         if (wr_out) begin
            output_enable_bit_reg <= hwdata[OUT_ENABLE_POS];
            toggle_on_match_a_reg <= hwdata[TOGGLE_A_POS];
            toggle_on_match_b_reg <= hwdata[TOGGLE_B_POS];
         end
      end
   end

   tecnt_run_t run_mode;
   tecnt_src_t count_src;
   logic [1:0] first_edge_sel;
   logic [1:0] second_edge_sel;
   logic       running;

   assign run_mode        = tecnt_run_t'(run_mode_reg);
   assign count_src       = tecnt_src_t'(clock_and_edge_select_reg[COUNT_SRC_LO_POS +: 2]);
   assign first_edge_sel  = clock_and_edge_select_reg[FIRST_EDGE_LO_POS +: 2];
   assign second_edge_sel = clock_and_edge_select_reg[SECOND_EDGE_LO_POS +: 2];
   assign running         = (run_mode != TECNT_RUN_STOP);

   ////////////////////////////////////////////////////////////////////////////
   // Prescaler: clock/4 enable pulse

   logic [1:0] prescale_reg;
   logic       tick_div4;

   assign tick_div4 = (prescale_reg == PRESCALE_LAST);

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         prescale_reg <= 2'h0;
      end else begin
         prescale_reg <= prescale_reg + 2'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers and edge filters

   logic [2:0] sync_a_reg;
   logic [2:0] sync_b_reg;
   logic [1:0] samp_a_reg;
   logic       lvl_a_reg;
   logic       lvl_b_reg;
   logic       started_once_reg;
   logic       edge_a;
   logic       edge_b;
   logic       lvl_a_next;
   logic       lvl_b_next;

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         sync_a_reg <= 3'h0;
         sync_b_reg <= 3'h0;
      end else begin
         sync_a_reg <= {sync_a_reg[1:0], event_input_a};
         sync_b_reg <= {sync_b_reg[1:0], capture_input_b};
      end
   end

   // Noise shorter than one clock/4 sample period never reaches the counter
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         samp_a_reg <= 2'h0;
      end else if (tick_div4 && (sync_a_reg[2] == sync_a_reg[1])) begin
         samp_a_reg <= {samp_a_reg[0], sync_a_reg[2]};
      end
   end

   always_comb begin
      lvl_a_next = lvl_a_reg;
      if (samp_a_reg[1] == samp_a_reg[0]) begin
         lvl_a_next = samp_a_reg[0];
      end
      lvl_b_next = lvl_b_reg;
      if (sync_b_reg[2] == sync_b_reg[1]) begin
         lvl_b_next = sync_b_reg[2];
      end
   end

   // Levels stay low until the first enable so a pulled-up pin reads as a rise
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         lvl_a_reg        <= 1'b0;
         lvl_b_reg        <= 1'b0;
         started_once_reg <= 1'b0;
      end else begin
         if (running) begin
            started_once_reg <= 1'b1;
         end
         if (running || started_once_reg) begin
            lvl_a_reg <= lvl_a_next;
            lvl_b_reg <= lvl_b_next;
         end
      end
   end

   assign edge_a = running & edge_hit(first_edge_sel, lvl_a_reg, lvl_a_next);
   assign edge_b = running & edge_hit(second_edge_sel, lvl_b_reg, lvl_b_next);

   ////////////////////////////////////////////////////////////////////////////
   // Count tick and counter

   logic count_tick;
   logic armed_reg;
   logic match_a;
   logic match_b;
   logic wrap;

   always_comb begin
      unique case (count_src)
         TECNT_SRC_CLK:      count_tick = 1'b1;
         TECNT_SRC_CLK_DIV4: count_tick = tick_div4;
         TECNT_SRC_WATCH:    count_tick = watch_timer_tick;
         TECNT_SRC_EDGE_A:   count_tick = edge_a;
      endcase
   end

   // First tick after start only aligns the counter with the count clock
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         armed_reg <= 1'b0;
      end else if (!running) begin
         armed_reg <= 1'b0;
      end else if (count_tick) begin
         armed_reg <= 1'b1;
      end
   end

   // Armed flag drops a cycle after a stop write, so gate on run mode to avoid a late match
   assign match_a = running & armed_reg & count_tick & (count_value_reg == compare_capture_a_reg);
   assign match_b = running & armed_reg & count_tick & (count_value_reg == compare_capture_b_reg);
   assign wrap    = running & armed_reg & count_tick & (count_value_reg == COUNT_MAX);

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         count_value_reg <= COUNT_RESET;
      end else if (!running) begin
         count_value_reg <= COUNT_RESET;
      end else if (run_mode == TECNT_RUN_EDGE_CLR && edge_a) begin
         count_value_reg <= COUNT_RESET;
      end else if (run_mode == TECNT_RUN_MATCH_CLR && match_a) begin
         count_value_reg <= COUNT_RESET;
      end else if (armed_reg && count_tick) begin
         count_value_reg <= count_value_reg + 16'h0001;
      end
   end

   // Wrap beats a simultaneous software clear
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         overflow_flag_reg <= 1'b0;
      end else if (wrap) begin
         overflow_flag_reg <= 1'b1;
      end else if (!running) begin
         overflow_flag_reg <= 1'b0;
      end else if (wr_mode) begin
         overflow_flag_reg <= hwdata[OVERFLOW_POS];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Match events and timer output

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         match_irq_a <= 1'b0;
         match_irq_b <= 1'b0;
      end else begin
         match_irq_a <= match_a;
         match_irq_b <= match_b;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         out_level_reg <= 1'b0;
      end else if (wr_out && hwdata[LEVEL_SET_POS]) begin
         out_level_reg <= 1'b1;
      end else if (wr_out && hwdata[LEVEL_CLEAR_POS]) begin
         out_level_reg <= 1'b0;
      end else if ((match_a && toggle_on_match_a_reg) != (match_b && toggle_on_match_b_reg)) begin
         out_level_reg <= ~out_level_reg;
      end
   end

   // Registered gating keeps the pin glitch-free; it trails the level by a cycle
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         timer_output_pin <= 1'b0;
      end else begin
         timer_output_pin <= output_enable_bit_reg & out_level_reg;
      end
   end

endmodule : tecnt_timer

// ==== dv/tecnt_timer_chk.sv ====
// Checker for the timer block: bus answers, pin level and match spacing.
// Assumes it is bound to tecnt_timer and sees only its ports.
`timescale 1ns/1ps

module tecnt_timer_chk
   import tecnt_pkg::*;
(
   // Clock and reset
   input wire logic        clock,
   input wire logic        rst_n,
   // Bus
   input wire logic        hsel,
   input wire logic [7:0]  haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic [31:0] hrdata,
   input wire logic        hreadyout,
   input wire logic        hresp,
   // Pins and events
   input wire logic        timer_output_pin,
   input wire logic        match_irq_a,
   input wire logic        match_irq_b
);
   logic        wr_q;
   logic [7:0]  a_q;
   logic [1:0]  run_q;
   logic [7:0]  sel_q;
   logic        oe_q;
   logic        tga_q;
   logic        tgb_q;
   logic [15:0] cmp_q;
   logic [15:0] gap;
   logic        gap_ok;

   ////////////////////////////////////////
   // Mirror of what software wrote, taken in the data phase
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         {wr_q, a_q, run_q, sel_q, oe_q, tga_q, tgb_q, cmp_q} <= '0;
      end else begin
         wr_q <= hsel && hready && htrans[1] && hwrite;
         a_q  <= haddr;
         if (wr_q && a_q == ADDR_RUN_MODE_CONTROL) run_q <= hwdata[3:2];
         if (wr_q && a_q == ADDR_CLOCK_EDGE_SEL) sel_q <= hwdata[7:0];
         if (wr_q && a_q == ADDR_OUTPUT_CONTROL) {tgb_q, tga_q, oe_q} <= {hwdata[4], hwdata[1:0]};
         if (wr_q && a_q == ADDR_COMPARE_A) cmp_q <= hwdata[15:0];
      end
   end

   // Any write spoils the spacing measurement until the next match
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         gap    <= 16'h0;
         gap_ok <= 1'b0;
      end else begin
         gap    <= match_irq_a ? 16'h1 : gap + 16'h1;
         gap_ok <= match_irq_a || (gap_ok && !wr_q);
      end
   end

   ////////////////////////////////////////
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   sequence rd_take;
      hsel && hready && htrans[1] && !hwrite;
   endsequence

   ready_always_a: assert property (hreadyout)
      else $error("hreadyout low");
   resp_okay_a: assert property (!hresp)
      else $error("hresp not OKAY");
   reset_quiet_a: assert property (disable iff (1'b0) !rst_n |=> hrdata == 32'h0 && !timer_output_pin)
      else $error("outputs not quiet after reset");
   unmapped_zero_a: assert property (rd_take ##0 haddr > ADDR_COMPARE_B |=> hrdata == 32'h0)
      else $error("unmapped read not zero");
   edge_sel_rd_a: assert property (rd_take ##0 haddr == ADDR_CLOCK_EDGE_SEL |=> hrdata == {24'h0, $past(sel_q)})
      else $error("edge select readback wrong");
   stop_quiet_a: assert property (run_q == 2'h0 && $past(run_q) == 2'h0 |-> !match_irq_a && !match_irq_b)
      else $error("match while stopped");
   pin_low_a: assert property (!oe_q && !$past(oe_q) |-> !timer_output_pin)
      else $error("output pin high while disabled");
   pin_toggle_a: assert property (match_irq_a && oe_q && tga_q && !(match_irq_b && tgb_q) |-> ##[1:2] $changed(timer_output_pin))
      else $error("output pin not inverted on match");
   match_gap_a: assert property (match_irq_a && gap_ok && run_q == 2'h3 && sel_q[1:0] == 2'h0 |-> gap == cmp_q + 16'h1)
      else $error("match spacing wrong");

endmodule : tecnt_timer_chk

bind tecnt_timer tecnt_timer_chk i_chk (.clock, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
   .hrdata, .hreadyout, .hresp, .timer_output_pin, .match_irq_a, .match_irq_b);

// ==== dv/tecnt_pins.sv ====
// Model of the pin sources: event pulses on input A, a companion level on B.
// Assumes its tasks are called right after a rising clock edge.
`timescale 1ns/1ps

module tecnt_pins (
   // Clock
   input  wire logic clock,
   // Pins
   output logic      event_input_a,
   output logic      capture_input_b
);
   initial begin
      event_input_a   = 1'b0;
      capture_input_b = 1'b0;
   end

   // Twelve clocks per phase outlast two clock/4 periods
   task pulses(input int n);
      repeat (n) begin
         repeat (12) @(posedge clock);
         event_input_a   <= 1'b0;
         capture_input_b <= ~capture_input_b;
         repeat (12) @(posedge clock);
         event_input_a   <= 1'b1;
      end
      repeat (24) @(posedge clock);
   endtask : pulses

   // Too short to be seen twice by the filter
   task glitch();
      event_input_a <= 1'b0;
      repeat (2) @(posedge clock);
      event_input_a <= 1'b1;
      repeat (24) @(posedge clock);
   endtask : glitch

   task set_level(input logic v);
      event_input_a <= v;
      repeat (16) @(posedge clock);
   endtask : set_level

endmodule : tecnt_pins

// ==== dv/tecnt_timer_bench.sv ====
// Self-checking bench for the timer block over AHB-Lite.
// Assumes the checker binds itself and the pin model drives inputs A and B.
`timescale 1ns/1ps

module tecnt_timer_bench
   import tecnt_pkg::*;
;
   logic        clock;
   logic        rst_n;
   logic        hsel;
   logic [7:0]  haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   logic        watch_timer_tick;
   logic        event_input_a;
   logic        capture_input_b;
   logic        timer_output_pin;
   logic        match_irq_a;
   logic        match_irq_b;
   logic [2:0]  wcnt = 3'h0;
   logic        pin_q = 1'b0;
   logic [31:0] rd;
   logic [1:0]  codes [3] = '{EDGE_FALL, EDGE_RISE, EDGE_BOTH};
   int          errors = 0;
   int          tests_run = 0;
   int          cyc = 0, last = 0, gap = 0, irq_n = 0, tog = 0, irqb_n = 0;

   tecnt_timer i_dut (.clock, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
      .hready(hreadyout), .hrdata, .hreadyout, .hresp, .watch_timer_tick, .event_input_a,
      .capture_input_b, .timer_output_pin, .match_irq_a, .match_irq_b);
   tecnt_pins i_pins (.clock, .event_input_a, .capture_input_b);

   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end

   ////////////////////////////////////////
   // Watch tick every fifth clock; match spacing and pin toggles counted here
   always @(posedge clock) begin
      cyc <= cyc + 1;
      wcnt <= (wcnt == 3'h4) ? 3'h0 : wcnt + 3'h1;
      watch_timer_tick <= (wcnt == 3'h4);
      pin_q <= timer_output_pin;
      if (timer_output_pin !== pin_q) tog <= tog + 1;
      if (match_irq_b === 1'b1) irqb_n <= irqb_n + 1;
      if (match_irq_a === 1'b1) begin
         irq_n <= irq_n + 1;
         gap   <= cyc - last;
         last  <= cyc;
      end
   end

   task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task wr(input logic [7:0] a, input logic [31:0] d);
      haddr  <= a;
      hwrite <= 1'b1;
      htrans <= 2'h2;
      do @(posedge clock); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clock); while (hreadyout !== 1'b1);
   endtask : wr

   task rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
      haddr  <= a;
      hwrite <= 1'b0;
      htrans <= 2'h2;
      do @(posedge clock); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      do @(posedge clock); while (hreadyout !== 1'b1);
      rd = hrdata;
      chk(what, rd, exp);
   endtask : rchk

   // Configuration is only touched while stopped, though the block also accepts writes in run
   task start(input logic [7:0] sel, input logic [15:0] cmp, input logic [7:0] ctl);
      wr(ADDR_RUN_MODE_CONTROL, 32'h0);
      wr(ADDR_CLOCK_EDGE_SEL, {24'h0, sel});
      wr(ADDR_COMPARE_A, {16'h0, cmp});
      wr(ADDR_OUTPUT_CONTROL, {24'h0, ctl});
      wr(ADDR_RUN_MODE_CONTROL, 32'hc);
   endtask : start

   task wait_irq(input int n);
      int k;
      k = 0;
      while (irq_n < n && k < 3000) begin
         @(posedge clock);
         k++;
      end
   endtask : wait_irq

   task interval(input logic [1:0] src, input logic [15:0] cmp, input logic [7:0] ctl, input int eg, input int et);
      int n0;
      int t0;
      int b0;
      start({6'h0, src}, cmp, ctl);
      n0 = irq_n;
      wait_irq(n0 + 1);
      t0 = tog;
      b0 = irqb_n;
      wait_irq(n0 + 3);
      chk("match interval", gap, eg);
      chk("output toggles", tog - t0, et);
      chk("match b events", irqb_n - b0, 2);
   endtask : interval

   task final_report();
      if (errors == 0 && tests_run > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : final_report

   ////////////////////////////////////////
   initial begin
      rst_n  <= 1'b0;
      hsel   <= 1'b1;
      haddr  <= 8'h00;
      htrans <= 2'h0;
      hwrite <= 1'b0;
      hwdata <= 32'h0000_0000;
      repeat (12) @(posedge clock);
      rst_n <= 1'b1;
      @(posedge clock);
      rchk("edge select reset", ADDR_CLOCK_EDGE_SEL, 32'h0);
      rchk("unmapped read", 8'h1c, 32'h0);
      foreach (codes[i]) begin
         wr(ADDR_CLOCK_EDGE_SEL, {24'h0, codes[i], codes[i], 4'h0});
         rchk("edge select", ADDR_CLOCK_EDGE_SEL, {24'h0, codes[i], codes[i], 4'h0});
      end
      // A transfer with the slave deselected must leave the register alone
      hsel <= 1'b0;
      wr(ADDR_CLOCK_EDGE_SEL, 32'h0000_00ff);
      hsel <= 1'b1;
      rchk("deselected write", ADDR_CLOCK_EDGE_SEL, {24'h0, EDGE_BOTH, EDGE_BOTH, 4'h0});
      // Event counting with output disabled, pin high before the very first start
      i_pins.set_level(1'b1);
      start(8'h13, 16'h2, 8'h00);
      i_pins.glitch();
      i_pins.pulses(2);
      chk("event match early", irq_n, 0);
      i_pins.pulses(1);
      chk("event match first", irq_n, 1);
      i_pins.pulses(3);
      chk("event match next", irq_n, 2);
      start(8'h13, 16'h2, 8'h00);
      i_pins.pulses(3);
      chk("restart high level", irq_n, 2);
      i_pins.pulses(1);
      chk("restart match", irq_n, 3);
      interval(2'h0, 16'h4, 8'h03, 5, 2);
      interval(2'h1, 16'h2, 8'h03, 12, 2);
      interval(2'h2, 16'h2, 8'h01, 15, 0);
      interval(2'h0, 16'h3, 8'h02, 4, 0);
      chk("pin disabled", 32'(timer_output_pin), 32'h0);
      wr(ADDR_RUN_MODE_CONTROL, 32'h0);
      rchk("count after stop", ADDR_COUNT_VALUE, 32'h0);
      // Free run long enough to wrap the 16-bit count once
      wr(ADDR_CLOCK_EDGE_SEL, 32'h0);
      wr(ADDR_RUN_MODE_CONTROL, 32'h4);
      repeat (65600) @(posedge clock);
      rchk("overflow flag", ADDR_RUN_MODE_CONTROL, 32'h5);
      wr(ADDR_RUN_MODE_CONTROL, 32'h4);
      rchk("overflow cleared", ADDR_RUN_MODE_CONTROL, 32'h4);
      final_report();
   end

   // Run takes about 66k clocks, mostly the overflow wait
   initial begin
      repeat (90000) @(posedge clock);
      errors++;
      final_report();
   end

endmodule : tecnt_timer_bench
